// ==== design/cgr_pkg.sv ====
// package: register map, field layout, reset values and types for the calibration register bank
package cgr_pkg;
	// register indices; each 8-bit register takes one aligned word
	localparam logic [7:0]  OFFSET_CAL_LOW_IDX    = 8'h07;
	localparam logic [7:0]  OFFSET_CAL_MID_IDX    = 8'h08;
	localparam logic [7:0]  OFFSET_CAL_HIGH_IDX   = 8'h09;
	localparam logic [7:0]  SCALE_CAL_LOW_IDX     = 8'h0a;
	localparam logic [7:0]  SCALE_CAL_MID_IDX     = 8'h0b;
	localparam logic [7:0]  SCALE_CAL_HIGH_IDX    = 8'h0c;
	localparam logic [7:0]  SPARE_A_IDX           = 8'h0d;
	localparam logic [7:0]  SPARE_B_IDX           = 8'h0e;
	localparam logic [7:0]  SPARE_C_IDX           = 8'h0f;
	localparam logic [7:0]  AMPLIFIER_CONFIG_IDX  = 8'h10;
	localparam logic [7:0]  INPUT_SELECT_IDX      = 8'h11;
	// byte address is four times the index
	localparam logic [11:0] OFFSET_CAL_LOW_ADDR   = {2'b00, OFFSET_CAL_LOW_IDX, 2'b00};
	localparam logic [11:0] OFFSET_CAL_MID_ADDR   = {2'b00, OFFSET_CAL_MID_IDX, 2'b00};
	localparam logic [11:0] OFFSET_CAL_HIGH_ADDR  = {2'b00, OFFSET_CAL_HIGH_IDX, 2'b00};
	localparam logic [11:0] SCALE_CAL_LOW_ADDR    = {2'b00, SCALE_CAL_LOW_IDX, 2'b00};
	localparam logic [11:0] SCALE_CAL_MID_ADDR    = {2'b00, SCALE_CAL_MID_IDX, 2'b00};
	localparam logic [11:0] SCALE_CAL_HIGH_ADDR   = {2'b00, SCALE_CAL_HIGH_IDX, 2'b00};
	localparam logic [11:0] SPARE_A_ADDR          = {2'b00, SPARE_A_IDX, 2'b00};
	localparam logic [11:0] SPARE_B_ADDR          = {2'b00, SPARE_B_IDX, 2'b00};
	localparam logic [11:0] SPARE_C_ADDR          = {2'b00, SPARE_C_IDX, 2'b00};
	localparam logic [11:0] AMPLIFIER_CONFIG_ADDR = {2'b00, AMPLIFIER_CONFIG_IDX, 2'b00};
	localparam logic [11:0] INPUT_SELECT_ADDR     = {2'b00, INPUT_SELECT_IDX, 2'b00};

	// reset values
	localparam logic [7:0]  OFFSET_CAL_RST        = 8'h00;
	localparam logic [7:0]  SCALE_CAL_LOW_RST     = 8'h00;
	localparam logic [7:0]  SCALE_CAL_MID_RST     = 8'h00;
	localparam logic [7:0]  SCALE_CAL_HIGH_RST    = 8'h40;
	localparam logic [7:0]  AMPLIFIER_CONFIG_RST  = 8'h00;
	localparam logic [7:0]  INPUT_SELECT_RST      = 8'hff;
	localparam logic [7:0]  SPARE_READ_VALUE      = 8'h00;

	// amplifier_config fields
	localparam int          BYPASS_BIT            = 7;
	localparam int          GAIN_MSB              = 2;
	localparam logic [7:0]  AMPLIFIER_WRITE_MASK  = 8'h87;

	// scale shift, so unity is the scale word 400000h, and the data width
	localparam int          SCALE_SHIFT           = 22;
	localparam int          DATA_W                = 24;

	// gain field encodings
	typedef enum logic [2:0] {
		CGR_GAIN_1   = 3'b000,
		CGR_GAIN_64  = 3'b110,
		CGR_GAIN_128 = 3'b111
	} cgr_gain_t;

	// input selector codes (one nibble)
	localparam logic [3:0]  SEL_AIN_FIRST         = 4'h3;
	localparam logic [3:0]  SEL_AIN_LAST          = 4'h8;
	localparam logic [3:0]  SEL_TEMP_SENSOR       = 4'hb;
	localparam logic [3:0]  SEL_OPEN              = 4'he;
	localparam logic [3:0]  SEL_COMMON_MODE       = 4'hf;

	// decoded input selection for one side of the multiplexer
	typedef struct packed {
		logic       ain_valid;
		logic [2:0] ain_index;
		logic       temp_sensor;
		logic       open;
		logic       common_mode;
		logic       reserved;
	} cgr_input_t;

	// decoded amplifier setting
	typedef struct packed {
		logic       bypass;
		logic [7:0] gain;
		logic       gain_reserved;
	} cgr_amp_t;
endpackage : cgr_pkg

// ==== design/cgr_cal_path.sv ====
// calibration datapath: offset subtraction, then scale, then clip
`timescale 1ns/1ns
`default_nettype none
module cgr_cal_path #(
	parameter int W = cgr_pkg::DATA_W
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                raw_valid,
	input  wire logic signed [W-1:0] raw_data,
	input  wire logic        [W-1:0] offset_cal_word,
	input  wire logic        [W-1:0] scale_cal_word,
	output var  logic                cal_valid,
	output var  logic signed [W-1:0] cal_data,
	output var  logic                cal_clipped
);
	localparam logic signed [2*W+1:0] MAX_CODE = (2*W+2)'((64'sd1 <<< (W-1)) - 1);
	localparam logic signed [2*W+1:0] MIN_CODE = (2*W+2)'(-(64'sd1 <<< (W-1)));

	logic signed [W:0]       diff;
	logic signed [W:0]       diff_q;
	logic                    valid_q;
	logic signed [2*W+1:0]   product;
	logic signed [2*W+1:0]   scaled;

	// offset word is two's complement; one extra bit keeps the difference exact
	assign diff = (W+1)'(raw_data) - (W+1)'($signed(offset_cal_word));

	// stage one registers the offset-corrected value so scaling strictly follows it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			diff_q  <= '0;
			valid_q <= 1'b0;
		end
		else
		begin
			diff_q  <= diff;
			valid_q <= raw_valid;
		end
	end

	// scale word is unsigned; zero-extend so it multiplies as a positive number
	// both factors are widened first so the product is never cut to operand width
	assign product = (2*W+2)'(diff_q) * (2*W+2)'($signed({1'b0, scale_cal_word}));
	assign scaled  = product >>> cgr_pkg::SCALE_SHIFT;

	// stage two clips instead of wrapping
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cal_data    <= '0;
			cal_valid   <= 1'b0;
			cal_clipped <= 1'b0;
		end
		else
		begin
			cal_valid <= valid_q;
			if (scaled > MAX_CODE)
			begin
				cal_data    <= W'(MAX_CODE);
				cal_clipped <= 1'b1;
			end
			else if (scaled < MIN_CODE)
			begin
				cal_data    <= W'(MIN_CODE);
				cal_clipped <= 1'b1;
			end
			else
			begin
				cal_data    <= W'(scaled);
				cal_clipped <= 1'b0;
			end
		end
	end

	property p_clip_range;
		@(posedge pclk) disable iff (!presetn)
		(scaled > MAX_CODE) |=> (cal_data == W'(MAX_CODE)) && cal_clipped;
	endproperty
	a_clip_range: assert property (p_clip_range) else $error("high clip missing");

	property p_order;
		@(posedge pclk) disable iff (!presetn)
		raw_valid |=> valid_q ##1 cal_valid;
	endproperty
	a_order: assert property (p_order) else $error("result latency wrong");
endmodule : cgr_cal_path
`default_nettype wire

// ==== design/cgr_regs.sv ====
// calibration and gain register bank with APB slave and calibration datapath
//
// Overview of operation
// - 24-bit offset word, three bytes, resets zero
// - offset word is signed two's complement
// - offset subtracted from raw result first
// - 24-bit unsigned scale word, three bytes
// - scale word resets to unity, 400000h
// - result multiplied by scale over 400000h
// - scaling always after offset subtraction
// - three spare locations read-only, read zero
// - amplifier bit 7 selects bypass
// - gain codes 000, 110, 111; host writes zeros
// - input selector resets to FFh
// - selector nibbles decoded to inputs
`timescale 1ns/1ns
`default_nettype none
module cgr_regs #(
	parameter int W = cgr_pkg::DATA_W
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output var  logic [31:0]         prdata,
	output var  logic                pready,
	output var  logic                pslverr,
	input  wire logic                raw_valid,
	input  wire logic signed [W-1:0] raw_data,
	output var  logic                cal_valid,
	output var  logic signed [W-1:0] cal_data,
	output var  logic                cal_clipped,
	output var  cgr_pkg::cgr_amp_t   amp_setting,
	output var  cgr_pkg::cgr_input_t positive_input_sel,
	output var  cgr_pkg::cgr_input_t negative_input_sel
);
	logic [7:0]   offset_cal_low;
	logic [7:0]   offset_cal_mid;
	logic [7:0]   offset_cal_high;
	logic [7:0]   scale_cal_low;
	logic [7:0]   scale_cal_mid;
	logic [7:0]   scale_cal_high;
	logic [7:0]   amplifier_config;
	logic [7:0]   input_select;
	logic [W-1:0] offset_cal_word;
	logic [W-1:0] scale_cal_word;
	logic         wr_en;
	logic         mapped;
	logic [7:0]   rd_byte;

	// single-cycle access phase: the slave never inserts wait states
	assign pready = 1'b1;
	assign wr_en  = psel && penable && pwrite && pstrb[0];

	// address decode, also flags unmapped addresses
	always_comb
	begin
		mapped  = 1'b1;
		rd_byte = 8'h00;
		case (paddr)
			cgr_pkg::OFFSET_CAL_LOW_ADDR:   rd_byte = offset_cal_low;
			cgr_pkg::OFFSET_CAL_MID_ADDR:   rd_byte = offset_cal_mid;
			cgr_pkg::OFFSET_CAL_HIGH_ADDR:  rd_byte = offset_cal_high;
			cgr_pkg::SCALE_CAL_LOW_ADDR:    rd_byte = scale_cal_low;
			cgr_pkg::SCALE_CAL_MID_ADDR:    rd_byte = scale_cal_mid;
			cgr_pkg::SCALE_CAL_HIGH_ADDR:   rd_byte = scale_cal_high;
			cgr_pkg::SPARE_A_ADDR,
			cgr_pkg::SPARE_B_ADDR,
			cgr_pkg::SPARE_C_ADDR:          rd_byte = cgr_pkg::SPARE_READ_VALUE;
			cgr_pkg::AMPLIFIER_CONFIG_ADDR: rd_byte = amplifier_config;
			cgr_pkg::INPUT_SELECT_ADDR:     rd_byte = input_select;
			default:                        mapped  = 1'b0;
		endcase
	end

	// error on unmapped addresses only; spare locations silently drop writes
	assign pslverr = psel && penable && !mapped;

	// read data is registered at the edge that ends the setup phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= {24'h00_0000, rd_byte};
	end

	// offset calibration bytes, lowest byte at lowest address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			offset_cal_low  <= cgr_pkg::OFFSET_CAL_RST;
			offset_cal_mid  <= cgr_pkg::OFFSET_CAL_RST;
			offset_cal_high <= cgr_pkg::OFFSET_CAL_RST;
		end
		else if (wr_en)
		begin
			if (paddr == cgr_pkg::OFFSET_CAL_LOW_ADDR)
				offset_cal_low <= pwdata[7:0];
			if (paddr == cgr_pkg::OFFSET_CAL_MID_ADDR)
				offset_cal_mid <= pwdata[7:0];
			if (paddr == cgr_pkg::OFFSET_CAL_HIGH_ADDR)
				offset_cal_high <= pwdata[7:0];
		end
	end

	// scale calibration bytes; reset value gives unity gain
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scale_cal_low  <= cgr_pkg::SCALE_CAL_LOW_RST;
			scale_cal_mid  <= cgr_pkg::SCALE_CAL_MID_RST;
			scale_cal_high <= cgr_pkg::SCALE_CAL_HIGH_RST;
		end
		else if (wr_en)
		begin
			if (paddr == cgr_pkg::SCALE_CAL_LOW_ADDR)
				scale_cal_low <= pwdata[7:0];
			if (paddr == cgr_pkg::SCALE_CAL_MID_ADDR)
				scale_cal_mid <= pwdata[7:0];
			if (paddr == cgr_pkg::SCALE_CAL_HIGH_ADDR)
				scale_cal_high <= pwdata[7:0];
		end
	end

	// amplifier bits 6:3 are kept at zero whatever the host writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			amplifier_config <= cgr_pkg::AMPLIFIER_CONFIG_RST;
		else if (wr_en && paddr == cgr_pkg::AMPLIFIER_CONFIG_ADDR)
			amplifier_config <= pwdata[7:0] & cgr_pkg::AMPLIFIER_WRITE_MASK;
	end

	// input selector register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			input_select <= cgr_pkg::INPUT_SELECT_RST;
		else if (wr_en && paddr == cgr_pkg::INPUT_SELECT_ADDR)
			input_select <= pwdata[7:0];
	end

	assign offset_cal_word = {offset_cal_high, offset_cal_mid, offset_cal_low};
	assign scale_cal_word  = {scale_cal_high, scale_cal_mid, scale_cal_low};

	// amplifier decode; reserved gain codes fall back to unity
	always_comb
	begin
		amp_setting        = '0;
		amp_setting.bypass = amplifier_config[cgr_pkg::BYPASS_BIT];
		case (cgr_pkg::cgr_gain_t'(amplifier_config[cgr_pkg::GAIN_MSB:0]))
			cgr_pkg::CGR_GAIN_1:   amp_setting.gain = 8'h01;
			cgr_pkg::CGR_GAIN_64:  amp_setting.gain = 8'h40;
			cgr_pkg::CGR_GAIN_128: amp_setting.gain = 8'h80;
			default:
			begin
				amp_setting.gain          = 8'h01;
				amp_setting.gain_reserved = 1'b1;
			end
		endcase
	end

	// both selector nibbles decode the same way, so one generate loop
	for (genvar s = 0; s < 2; s++)
	begin : g_sel
		logic [3:0]          code;
		cgr_pkg::cgr_input_t dec;
		assign code = input_select[s*4 +: 4];
		always_comb
		begin
			dec = '0;
			if (code >= cgr_pkg::SEL_AIN_FIRST && code <= cgr_pkg::SEL_AIN_LAST)
			begin
				dec.ain_valid = 1'b1;
				dec.ain_index = 3'(code - cgr_pkg::SEL_AIN_FIRST);
			end
			else if (code == cgr_pkg::SEL_TEMP_SENSOR)
				dec.temp_sensor = 1'b1;
			else if (code == cgr_pkg::SEL_OPEN)
				dec.open = 1'b1;
			else if (code == cgr_pkg::SEL_COMMON_MODE)
				dec.common_mode = 1'b1;
			else
				dec.reserved = 1'b1;
		end
	end
	assign positive_input_sel = g_sel[1].dec;
	assign negative_input_sel = g_sel[0].dec;

	cgr_cal_path #(
		.W (W)
	) u_cal (
		.pclk            (pclk),
		.presetn         (presetn),
		.raw_valid       (raw_valid),
		.raw_data        (raw_data),
		.offset_cal_word (offset_cal_word),
		.scale_cal_word  (scale_cal_word),
		.cal_valid       (cal_valid),
		.cal_data        (cal_data),
		.cal_clipped     (cal_clipped)
	);

	// assertions
	sequence s_setup_read;
		psel && !penable && !pwrite;
	endsequence
	sequence s_access_read;
		psel && penable && !pwrite;
	endsequence

	property p_spare_zero;
		@(posedge pclk) disable iff (!presetn)
		(s_setup_read ##0 (paddr == cgr_pkg::SPARE_A_ADDR || paddr == cgr_pkg::SPARE_B_ADDR
			|| paddr == cgr_pkg::SPARE_C_ADDR)) ##1 s_access_read |-> prdata == 32'h0;
	endproperty
	a_spare_zero: assert property (p_spare_zero) else $error("spare read not zero");

	property p_read_back;
		@(posedge pclk) disable iff (!presetn)
		s_setup_read ##0 (paddr == cgr_pkg::INPUT_SELECT_ADDR)
			|=> prdata[7:0] == input_select;
	endproperty
	a_read_back: assert property (p_read_back) else $error("selector readback wrong");

	property p_amp_mask;
		@(posedge pclk) disable iff (!presetn)
		(amplifier_config & ~cgr_pkg::AMPLIFIER_WRITE_MASK) == 8'h00;
	endproperty
	a_amp_mask: assert property (p_amp_mask) else $error("amp reserved bits set");

	property p_bypass;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == cgr_pkg::AMPLIFIER_CONFIG_ADDR)
			|=> amp_setting.bypass == $past(pwdata[cgr_pkg::BYPASS_BIT]);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass not applied");

	property p_offset_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == cgr_pkg::OFFSET_CAL_HIGH_ADDR)
			|=> offset_cal_word[W-1:W-8] == $past(pwdata[7:0]);
	endproperty
	a_offset_write: assert property (p_offset_write) else $error("offset high byte");

	property p_scale_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == cgr_pkg::SCALE_CAL_LOW_ADDR)
			|=> scale_cal_word[7:0] == $past(pwdata[7:0]);
	endproperty
	a_scale_write: assert property (p_scale_write) else $error("scale low byte");

	property p_unity;
		@(posedge pclk) disable iff (!presetn)
		(raw_valid && offset_cal_word == '0 && scale_cal_word == 24'h400000) ##1
			($stable(offset_cal_word) && $stable(scale_cal_word))
			|=> cal_data == $past(raw_data, 2);
	endproperty
	a_unity: assert property (p_unity) else $error("unity path altered data");

	property p_gain_128;
		@(posedge pclk) disable iff (!presetn)
		amplifier_config[cgr_pkg::GAIN_MSB:0] == 3'b111 |-> amp_setting.gain == 8'h80;
	endproperty
	a_gain_128: assert property (p_gain_128) else $error("gain 128 decode");

	property p_gain_reserved;
		@(posedge pclk) disable iff (!presetn)
		!(amplifier_config[cgr_pkg::GAIN_MSB:0] inside
			{cgr_pkg::CGR_GAIN_1, cgr_pkg::CGR_GAIN_64, cgr_pkg::CGR_GAIN_128})
			|-> amp_setting.gain_reserved && amp_setting.gain == 8'h01;
	endproperty
	a_gain_reserved: assert property (p_gain_reserved) else $error("reserved gain decode");

	property p_sel_reserved;
		@(posedge pclk) disable iff (!presetn)
		(input_select[7:4] < cgr_pkg::SEL_AIN_FIRST) |-> positive_input_sel.reserved;
	endproperty
	a_sel_reserved: assert property (p_sel_reserved) else $error("reserved select decode");

	property p_spare_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && (paddr == cgr_pkg::SPARE_A_ADDR || paddr == cgr_pkg::SPARE_B_ADDR
			|| paddr == cgr_pkg::SPARE_C_ADDR))
			|=> $stable(offset_cal_word) && $stable(scale_cal_word) && $stable(input_select);
	endproperty
	a_spare_write: assert property (p_spare_write) else $error("spare write landed");

	property p_common_mode;
		@(posedge pclk) disable iff (!presetn)
		(input_select[3:0] == cgr_pkg::SEL_COMMON_MODE) |-> negative_input_sel.common_mode;
	endproperty
	a_common_mode: assert property (p_common_mode) else $error("common mode decode");
endmodule : cgr_regs
`default_nettype wire

// ==== sim/cgr_host.sv ====
// host model: APB master that configures the calibration register bank
`timescale 1ns/1ns
`default_nettype none
module cgr_host (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [11:0] paddr,
	output var  logic [31:0] pwdata,
	output var  logic [3:0]  pstrb
);
	// bus idle from time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
	end

	// one transfer; the request is held until pready is seen high at an edge
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		// released lines are inverted so stale values never pass for fresh ones
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : cgr_host
`default_nettype wire

// ==== sim/cgr_regs_test.sv ====
// testbench: register map, amplifier and selector decode, calibration datapath
`timescale 1ns/1ns
`default_nettype none
module cgr_regs_test;
	logic                pclk;
	logic                presetn;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [11:0]         paddr;
	logic [31:0]         pwdata;
	logic [3:0]          pstrb;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                raw_valid;
	logic signed [23:0]  raw_data;
	logic                cal_valid;
	logic signed [23:0]  cal_data;
	logic                cal_clipped;
	cgr_pkg::cgr_amp_t   amp_setting;
	cgr_pkg::cgr_input_t positive_input_sel;
	cgr_pkg::cgr_input_t negative_input_sel;
	int                  num_errors = 0;
	int                  n_compared = 0;
	int                  cycles = 0;

	cgr_host host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb));
	cgr_regs #(.W(24)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .raw_valid(raw_valid), .raw_data(raw_data),
		.cal_valid(cal_valid), .cal_data(cal_data), .cal_clipped(cal_clipped),
		.amp_setting(amp_setting), .positive_input_sel(positive_input_sel),
		.negative_input_sel(negative_input_sel));

	// 100 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	// a hang costs a mismatch; the run needs well under a thousand cycles
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			num_errors++;
			$display("mismatch at %0t: timeout", $time);
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic ee);
		logic [31:0] d;
		logic        e;
		host.xfer(1'b1, a, {24'h0, v}, d, e);
		check({31'h0, e}, {31'h0, ee}, "write error");
	endtask : wr

	// read data is only judged where no error is expected
	task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic ee);
		logic [31:0] d;
		logic        e;
		host.xfer(1'b0, a, 32'h0, d, e);
		check({31'h0, e}, {31'h0, ee}, "read error");
		if (!ee)
			check(d, {24'h0, x}, "read data");
	endtask : rd

	function automatic cgr_pkg::cgr_input_t dec(input logic [3:0] c);
		cgr_pkg::cgr_input_t e;
		e = '0;
		e.ain_valid = (c >= 4'h3 && c <= 4'h8);
		e.ain_index = e.ain_valid ? 3'(c - 4'h3) : 3'h0;
		e.temp_sensor = (c == 4'hb);
		e.open = (c == 4'he);
		e.common_mode = (c == 4'hf);
		e.reserved = !(e.ain_valid || e.temp_sensor || e.open || e.common_mode);
		return e;
	endfunction : dec

	// clipped flag on top of the 24-bit calibrated result
	function automatic logic [24:0] cal_ref(input logic signed [23:0] r,
		input logic signed [23:0] o, input logic [23:0] s);
		longint p;
		p = ((longint'(r) - longint'(o)) * longint'(s)) >>> 22;
		if (p > 64'sh7fffff)
			return {1'b1, 24'h7fffff};
		if (p < -64'sh800000)
			return {1'b1, 24'h800000};
		return {1'b0, p[23:0]};
	endfunction : cal_ref

	task automatic t_reset();
		logic [7:0] rv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00,
			8'h00, 8'h00, 8'hff};
		for (int i = 0; i < 11; i++)
			rd(12'(cgr_pkg::OFFSET_CAL_LOW_ADDR + 4 * i), rv[i], 1'b0);
		rd(12'h048, 8'h00, 1'b1);
		rd(12'h018, 8'h00, 1'b1);
		check({31'h0, pready}, 32'h1, "pready");
		check({22'h0, amp_setting}, {22'h0, 1'b0, 8'd1, 1'b0}, "amp reset");
		check({24'h0, positive_input_sel}, {24'h0, dec(4'hf)}, "pos reset");
		check({24'h0, negative_input_sel}, {24'h0, dec(4'hf)}, "neg reset");
		$display("test reset done, mismatches %0d", num_errors);
	endtask : t_reset

	task automatic t_regs();
		for (int i = 0; i < 6; i++)
		begin
			wr(12'(cgr_pkg::OFFSET_CAL_LOW_ADDR + 4 * i), {4'(i), 4'ha}, 1'b0);
			rd(12'(cgr_pkg::OFFSET_CAL_LOW_ADDR + 4 * i), {4'(i), 4'ha}, 1'b0);
		end
		for (int i = 0; i < 3; i++)
		begin
			wr(12'(cgr_pkg::SPARE_A_ADDR + 4 * i), 8'hff, 1'b0);
			rd(12'(cgr_pkg::SPARE_A_ADDR + 4 * i), 8'h00, 1'b0);
		end
		wr(12'h048, 8'h55, 1'b1);
		$display("test regs done, mismatches %0d", num_errors);
	endtask : t_regs

	task automatic t_amp();
		logic [7:0] eg;
		logic       er;
		for (int g = 0; g < 8; g++)
			for (int b = 0; b < 2; b++)
			begin
				// only 1, 64 and 128 exist; reserved codes fall back to unity and are flagged
				eg = (g == 6) ? 8'd64 : ((g == 7) ? 8'd128 : 8'd1);
				er = (g >= 1 && g <= 5);
				// host keeps bits 6:3 zero
				wr(cgr_pkg::AMPLIFIER_CONFIG_ADDR, {1'(b), 4'h0, 3'(g)}, 1'b0);
				rd(cgr_pkg::AMPLIFIER_CONFIG_ADDR, {1'(b), 4'h0, 3'(g)}, 1'b0);
				check({22'h0, amp_setting}, {22'h0, 1'(b), eg, er}, "amp");
			end
		$display("test amp done, mismatches %0d", num_errors);
	endtask : t_amp

	task automatic t_mux();
		// every code on both nibbles, reserved ones included
		for (int i = 0; i < 16; i++)
		begin
			wr(cgr_pkg::INPUT_SELECT_ADDR, {4'(i), 4'(15 - i)}, 1'b0);
			// the register updates at the write edge, so look once it has settled
			#1;
			check({24'h0, positive_input_sel}, {24'h0, dec(4'(i))}, "pos sel");
			check({24'h0, negative_input_sel}, {24'h0, dec(4'(15 - i))}, "neg sel");
		end
		$display("test mux done, mismatches %0d", num_errors);
	endtask : t_mux

	task automatic t_cal();
		logic [23:0] r [8] = '{24'h100000, 24'h000100, 24'h001000, 24'h7ff000, 24'h900000,
			24'h900000, 24'h000100, 24'hffffff};
		logic [23:0] o [8] = '{24'h000000, 24'hffff00, 24'h000010, 24'hfff000, 24'h100000,
			24'h100001, 24'h000000, 24'h000000};
		logic [23:0] s [8] = '{24'h400000, 24'h400000, 24'h200000, 24'h400000, 24'h400000,
			24'h400000, 24'hc00000, 24'h200000};
		logic [24:0] e;
		for (int i = 0; i < 8; i++)
		begin
			for (int k = 0; k < 3; k++)
			begin
				wr(12'(cgr_pkg::OFFSET_CAL_LOW_ADDR + 4 * k), o[i][8 * k +: 8], 1'b0);
				wr(12'(cgr_pkg::SCALE_CAL_LOW_ADDR + 4 * k), s[i][8 * k +: 8], 1'b0);
			end
			e = cal_ref(r[i], o[i], s[i]);
			@(posedge pclk);
			raw_valid <= 1'b1;
			raw_data <= r[i];
			@(posedge pclk);
			raw_valid <= 1'b0;
			// result appears one edge after the raw value is taken
			#1;
			check({31'h0, cal_valid}, 32'h0, "early valid");
			@(posedge pclk);
			#1;
			check({31'h0, cal_valid}, 32'h1, "valid");
			check({8'h0, cal_data}, {8'h0, e[23:0]}, "cal data");
			check({31'h0, cal_clipped}, {31'h0, e[24]}, "clipped");
			@(posedge pclk);
			#1;
			check({31'h0, cal_valid}, 32'h0, "valid pulse");
		end
		$display("test cal done, mismatches %0d", num_errors);
	endtask : t_cal

	// main sequence: reset for 12 cycles, then each scenario
	initial
	begin
		presetn = 1'b0;
		raw_valid = 1'b0;
		raw_data = 24'h000000;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_amp();
		t_mux();
		t_cal();
		print_verdict();
	end
endmodule : cgr_regs_test
`default_nettype wire
